//--- verilog/bertc_pkg.sv
// Purpose: constants and types shared by the pattern control block
// Assumes: single core clock, byte-wide parallel register port
// Notes:   counts, synchronizer and bit checker sit outside this block
// Contract
// - Tap register holds a five-bit tap position in bits 4..0.
// - Tap position selects the generator stage used as feedback tap B.
// - Rising transmit load copies the four seed registers into the generator.
// - Transmit load bit is ORed with its pin before edge detection.
// - Pattern select one gives pseudorandom, zero gives repetitive pattern.
// - Rising count latch copies bit and error counts and clears counters.
// - Count latch bit is ORed with its pin before edge detection.
// - Capture while out of sync latches the last 32 received bits.
// - Realign disable zero allows auto resync; one suppresses it.
// - Rising manual realign restarts synchronisation to the receive input.
// - Loopback one ignores the receive input; transmit output carries on.
// - Transmit invert one inverts every transmitted bit.
// - Receive invert one inverts every received bit before checking.
// - Rising single-error bit corrupts exactly one transmitted bit.
// - Three-bit rate field inserts errors periodically.
// - Rate zero disables insertion; one to seven give one decade per step.
package bertc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_SEED3   = 8'h00;
  localparam logic [7:0] ADDR_SEED0   = 8'h03;
  localparam logic [7:0] ADDR_LENGTH  = 8'h04;
  localparam logic [7:0] ADDR_TAP     = 8'h05;
  localparam logic [7:0] ADDR_CTRL    = 8'h06;
  localparam logic [7:0] ADDR_ERRINS  = 8'h07;
  localparam logic [7:0] ADDR_BITCNT3 = 8'h08;
  localparam logic [7:0] ADDR_BITCNT0 = 8'h0b;
  localparam logic [7:0] ADDR_ERRCNT3 = 8'h0c;
  localparam logic [7:0] ADDR_ERRCNT0 = 8'h0f;
  localparam logic [7:0] ADDR_RXPAT3  = 8'h10;
  localparam logic [7:0] ADDR_RXPAT0  = 8'h13;
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam logic [7:0] MASK_TAP     = 8'h1f;
  localparam logic [7:0] MASK_LENGTH  = 8'h1f;
  localparam logic [7:0] MASK_ERRINS  = 8'h3f;
  localparam logic [3:0] ZERO_RUN_MAX = 4'he;
  // ****************************************
  // trigger indices
  // ****************************************
  localparam int TRIG_LOAD    = 0;
  localparam int TRIG_SERR    = 1;
  localparam int TRIG_LATCH   = 2;
  localparam int TRIG_CAPT    = 3;
  localparam int TRIG_REALIGN = 4;
  localparam int NUM_TRIG     = 5;
  localparam logic [4:0] TX_TRIG_MASK = 5'h03;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic transmit_load_trigger;
    logic zero_suppress_enable;
    logic pattern_kind_select;
    logic count_latch_trigger;
    logic receive_capture_trigger;
    logic auto_realign_disable;
    logic manual_realign_trigger;
    logic internal_loopback_enable;
  } bertc_ctrl_t;
  typedef struct packed {
    logic [1:0] unused;
    logic       tx_invert;
    logic       rx_invert;
    logic       single_error_inject;
    logic [2:0] error_rate_select;
  } bertc_errins_t;
  typedef struct packed {
    logic data;
    logic gen_zero;
  } bertc_txbit_t;
  // one insertion every 10^n transmitted bits
  function automatic logic [23:0] bertc_rate_period(input logic [2:0] sel);
    logic [23:0] p;
    p = 24'h000000;
    unique case (sel)
      3'h1: p = 24'h00000a;
      3'h2: p = 24'h000064;
      3'h3: p = 24'h0003e8;
      3'h4: p = 24'h002710;
      3'h5: p = 24'h0186a0;
      3'h6: p = 24'h0f4240;
      3'h7: p = 24'h989680;
      default: p = 24'h000000;
    endcase
    return p;
  endfunction
endpackage

//--- verilog/bertc_edge.sv
// Purpose: rising edge detect on register bit ORed with its pin
// Assumes: pins synchronous to core_clk
// Notes:   one registered pulse per low to high of the combined level
`timescale 1ns/10ps
module bertc_edge
  import bertc_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] reg_bits,
  input  wire logic [W-1:0] pin_bits,
  output logic      [W-1:0] rise
);
  logic [W-1:0] level;
  logic [W-1:0] level_q;

  assign level = reg_bits | pin_bits;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      level_q <= '0;
      rise    <= '0;
    end else begin
      level_q <= level;
      rise    <= level & ~level_q;
    end
  end

  chk_edge_or_pin: assert property (@(posedge core_clk) disable iff (!nrst)
    (level[0] && !$past(level[0])) |=> rise[0])
    else $error("load edge missed");
  chk_edge_level_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(level) == level |=> rise == '0)
    else $error("edge without new transition");
endmodule

//--- verilog/bertc_buf.sv
// Purpose: small fifo on the transmit bit path
// Assumes: producer honours in_ready
// Notes:   storage is flops, so depth must stay small
`timescale 1ns/10ps
module bertc_buf
  import bertc_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire bertc_txbit_t in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output bertc_txbit_t      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  bertc_txbit_t    mem [DEPTH];
  logic [AW-1:0]   wptr;
  logic [AW-1:0]   rptr;
  logic [AW:0]     count;
  logic            push;
  logic            pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count <= '0;
    end else begin
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  chk_buf_full_stall: assert property (@(posedge core_clk) disable iff (!nrst)
    count == (AW+1)'(DEPTH) |-> !in_ready)
    else $error("buffer accepts while full");
  chk_buf_bound: assert property (@(posedge core_clk) disable iff (!nrst)
    count <= (AW+1)'(DEPTH))
    else $error("buffer count overflow");
endmodule

//--- verilog/bertc_top.sv
// Purpose: pattern control of a bit error rate tester
// Assumes: tx_clk and rx_clk sampled as pins; their rising edges mark bits
// Notes:   generator runs ahead of the line and stalls on the buffer
`timescale 1ns/10ps
module bertc_top
  import bertc_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ale,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  input  wire logic        tx_load_pin,
  input  wire logic        count_latch_pin,
  input  wire logic        rx_capture_pin,
  input  wire logic        tx_clk,
  input  wire logic        tx_disable,
  output logic             tx_data,
  input  wire logic        rx_clk,
  input  wire logic        rx_data,
  input  wire logic        in_sync,
  input  wire logic [31:0] bit_count_in,
  input  wire logic [31:0] err_count_in,
  output logic             count_clear,
  output logic             realign_pulse,
  output logic             auto_realign_disable,
  output logic             rx_bit,
  output logic             rx_bit_valid
);
  // ****************************************
  // parallel port
  // ****************************************
  logic [7:0]    addr;
  logic [7:0]    wdata;
  logic          wr_q;
  logic          wr_act;
  logic          wr_commit;
  logic          rd_act;
  logic [7:0]    seed [4];
  logic [7:0]    length;
  logic [7:0]    tap;
  bertc_ctrl_t   ctrl;
  bertc_errins_t errins;
  logic [31:0]   bit_cnt_q;
  logic [31:0]   err_cnt_q;
  logic [31:0]   rx_pat_q;
  logic [7:0]    rdata;

  assign wr_act    = !cs_n && !wr_n;
  assign rd_act    = !cs_n && !rd_n;
  assign wr_commit = wr_q && !wr_act;

  // address follows the bus while ale is high, holds from its fall
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr <= RST_REG;
    end else if (ale) begin
      addr <= ad_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_q  <= 1'b0;
      wdata <= RST_REG;
    end else begin
      wr_q <= wr_act;
      if (wr_act) begin
        wdata <= ad_in;
      end
    end
  end

  // unused bits are dropped so they always read back zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        seed[i] <= RST_REG;
      end
      length <= RST_REG;
      tap    <= RST_REG;
      ctrl   <= bertc_ctrl_t'(RST_REG);
      errins <= bertc_errins_t'(RST_REG);
    end else if (wr_commit) begin
      unique case (addr)
        ADDR_LENGTH: length <= wdata & MASK_LENGTH;
        ADDR_TAP:    tap    <= wdata & MASK_TAP;
        ADDR_CTRL:   ctrl   <= bertc_ctrl_t'(wdata);
        ADDR_ERRINS: errins <= bertc_errins_t'(wdata & MASK_ERRINS);
        default: begin
          if (addr <= ADDR_SEED0) begin
            seed[2'(ADDR_SEED0 - addr)] <= wdata;
          end
        end
      endcase
    end
  end

  always_comb begin
    rdata = RST_REG;
    if (addr <= ADDR_SEED0) begin
      rdata = seed[2'(ADDR_SEED0 - addr)];
    end else if (addr == ADDR_LENGTH) begin
      rdata = length;
    end else if (addr == ADDR_TAP) begin
      rdata = tap;
    end else if (addr == ADDR_CTRL) begin
      rdata = ctrl;
    end else if (addr == ADDR_ERRINS) begin
      rdata = errins;
    end else if (addr >= ADDR_BITCNT3 && addr <= ADDR_BITCNT0) begin
      rdata = bit_cnt_q[8*(2'(ADDR_BITCNT0 - addr)) +: 8];
    end else if (addr >= ADDR_ERRCNT3 && addr <= ADDR_ERRCNT0) begin
      rdata = err_cnt_q[8*(2'(ADDR_ERRCNT0 - addr)) +: 8];
    end else if (addr >= ADDR_RXPAT3 && addr <= ADDR_RXPAT0) begin
      rdata = rx_pat_q[8*(2'(ADDR_RXPAT0 - addr)) +: 8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ad_out <= RST_REG;
      ad_oe  <= 1'b0;
    end else begin
      ad_out <= rdata;
      ad_oe  <= rd_act;
    end
  end

  // ****************************************
  // triggers
  // ****************************************
  logic [NUM_TRIG-1:0] trig_reg;
  logic [NUM_TRIG-1:0] trig_pin;
  logic [NUM_TRIG-1:0] rise;
  logic [NUM_TRIG-1:0] pend;
  logic [NUM_TRIG-1:0] apply;
  logic [NUM_TRIG-1:0] tick_mask;
  logic                tx_clk_q;
  logic                rx_clk_q;
  logic                tx_tick;
  logic                rx_tick;

  assign trig_reg = {ctrl.manual_realign_trigger, ctrl.receive_capture_trigger,
                     ctrl.count_latch_trigger, errins.single_error_inject,
                     ctrl.transmit_load_trigger};
  assign trig_pin = {1'b0, rx_capture_pin, count_latch_pin, 1'b0, tx_load_pin};

  bertc_edge #(.W(NUM_TRIG)) u_edge (
    .core_clk (core_clk),
    .nrst     (nrst),
    .reg_bits (trig_reg),
    .pin_bits (trig_pin),
    .rise     (rise)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      tx_clk_q <= tx_clk;
      rx_clk_q <= rx_clk;
    end
  end

  // a disabled transmitter freezes all transmit side actions
  assign tx_tick   = tx_clk && !tx_clk_q && !tx_disable;
  assign rx_tick   = rx_clk && !rx_clk_q;
  assign tick_mask = (TX_TRIG_MASK & {NUM_TRIG{tx_tick}}) |
                     (~TX_TRIG_MASK & {NUM_TRIG{rx_tick}});
  assign apply     = pend & tick_mask;

  // a new edge arriving as the old one is applied stays pending
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~apply) | rise;
    end
  end

  // ****************************************
  // pattern generator
  // ****************************************
  logic [31:0]  sh;
  logic [4:0]   len;
  logic [4:0]   tap_b;
  logic         gen_bit;
  logic         fb;
  logic [3:0]   zrun;
  logic         gen_run;
  logic         in_ready;
  logic         push;
  logic         out_valid;
  logic         pop;
  bertc_txbit_t gen_item;
  bertc_txbit_t out_item;

  assign len   = length[4:0];
  assign tap_b = tap[4:0];
  assign fb    = ctrl.pattern_kind_select ? (sh[len] ^ sh[tap_b]) : sh[len];
  always_comb begin
    gen_bit = sh[len];
    if (ctrl.zero_suppress_enable && zrun == ZERO_RUN_MAX) begin
      gen_bit = 1'b1;
    end
  end
  assign gen_item = '{data: gen_bit, gen_zero: !gen_bit};
  assign push     = gen_run && in_ready;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gen_run <= 1'b0;
    end else begin
      gen_run <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sh <= '0;
    end else if (apply[TRIG_LOAD]) begin
      sh <= {seed[3], seed[2], seed[1], seed[0]};
    end else if (push) begin
      sh <= {sh[30:0], fb};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      zrun <= '0;
    end else if (apply[TRIG_LOAD]) begin
      zrun <= '0;
    end else if (push) begin
      zrun <= gen_item.gen_zero ? zrun + 1'b1 : '0;
    end
  end

  bertc_buf #(.DEPTH(BUF_DEPTH)) u_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (gen_run),
    .in_ready  (in_ready),
    .in_data   (gen_item),
    .out_valid (out_valid),
    .out_ready (tx_tick),
    .out_data  (out_item)
  );

  // ****************************************
  // transmit line and error insertion
  // ****************************************
  logic [23:0] rate_cnt;
  logic [23:0] period;
  logic        auto_err;
  logic        bit_err;

  assign pop      = out_valid && tx_tick;
  assign period   = bertc_rate_period(errins.error_rate_select);
  assign auto_err = period != '0 && rate_cnt == period - 24'h000001;
  assign bit_err  = auto_err || pend[TRIG_SERR];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rate_cnt <= '0;
    end else if (period == '0) begin
      rate_cnt <= '0;
    end else if (pop) begin
      rate_cnt <= auto_err ? '0 : rate_cnt + 24'h000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_data <= 1'b0;
    end else if (pop) begin
      tx_data <= out_item.data ^ bit_err ^ errins.tx_invert;
    end
  end

  // ****************************************
  // receive side
  // ****************************************
  logic        rx_src;
  logic [31:0] hist;

  assign rx_src = ctrl.internal_loopback_enable ? tx_data : rx_data;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_bit       <= 1'b0;
      rx_bit_valid <= 1'b0;
      hist         <= '0;
    end else begin
      rx_bit_valid <= rx_tick;
      if (rx_tick) begin
        rx_bit <= rx_src ^ errins.rx_invert;
        hist   <= {hist[30:0], rx_src ^ errins.rx_invert};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bit_cnt_q   <= '0;
      err_cnt_q   <= '0;
      count_clear <= 1'b0;
    end else begin
      count_clear <= apply[TRIG_LATCH];
      if (apply[TRIG_LATCH]) begin
        bit_cnt_q <= bit_count_in;
        err_cnt_q <= err_count_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_pat_q <= '0;
    end else if (apply[TRIG_CAPT] && !in_sync) begin
      rx_pat_q <= hist;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      realign_pulse        <= 1'b0;
      auto_realign_disable <= 1'b0;
    end else begin
      realign_pulse        <= apply[TRIG_REALIGN];
      auto_realign_disable <= ctrl.auto_realign_disable;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_load_req;
    rise[TRIG_LOAD] && !apply[TRIG_LOAD];
  endsequence
  sequence s_load_done;
    apply[TRIG_LOAD] ##1 sh == $past({seed[3], seed[2], seed[1], seed[0]});
  endsequence

  chk_load_pending: assert property (@(posedge core_clk) disable iff (!nrst)
    s_load_req |=> pend[TRIG_LOAD])
    else $error("load edge not held pending");
  chk_load_seed: assert property (@(posedge core_clk) disable iff (!nrst)
    apply[TRIG_LOAD] |-> s_load_done)
    else $error("generator not loaded from seeds");
  chk_tx_invert: assert property (@(posedge core_clk) disable iff (!nrst)
    pop && !bit_err |=> tx_data == ($past(out_item.data) ^ $past(errins.tx_invert)))
    else $error("transmit bit wrong");
  chk_rx_loopback: assert property (@(posedge core_clk) disable iff (!nrst)
    rx_tick && ctrl.internal_loopback_enable
      |=> rx_bit == ($past(tx_data) ^ $past(errins.rx_invert)))
    else $error("loopback still uses receive pin");
  chk_rx_invert: assert property (@(posedge core_clk) disable iff (!nrst)
    rx_tick && !ctrl.internal_loopback_enable
      |=> rx_bit == ($past(rx_data) ^ $past(errins.rx_invert)) && rx_bit_valid)
    else $error("receive inversion wrong");
  chk_zero_run: assert property (@(posedge core_clk) disable iff (!nrst)
    push && ctrl.zero_suppress_enable && zrun == ZERO_RUN_MAX |-> gen_item.data)
    else $error("zero run too long");
  chk_count_latch: assert property (@(posedge core_clk) disable iff (!nrst)
    apply[TRIG_LATCH] |=> count_clear && bit_cnt_q == $past(bit_count_in)
      ##1 !count_clear || $past(apply[TRIG_LATCH]))
    else $error("count latch wrong");
  chk_capture_sync: assert property (@(posedge core_clk) disable iff (!nrst)
    apply[TRIG_CAPT] && in_sync |=> $stable(rx_pat_q))
    else $error("capture taken while in sync");
  chk_single_err: assert property (@(posedge core_clk) disable iff (!nrst)
    apply[TRIG_SERR] && !rise[TRIG_SERR] |-> bit_err ##1 !pend[TRIG_SERR])
    else $error("single error not applied once");
  chk_rate_off: assert property (@(posedge core_clk) disable iff (!nrst)
    errins.error_rate_select == 3'h0 |-> !auto_err ##1 rate_cnt == '0)
    else $error("insertion with rate zero");
  chk_realign_cause: assert property (@(posedge core_clk) disable iff (!nrst)
    realign_pulse |-> $past(apply[TRIG_REALIGN]) && $past(rx_tick))
    else $error("realign without receive edge");
  chk_tap_field: assert property (@(posedge core_clk) disable iff (!nrst)
    tap[7:5] == 3'h0 && errins.unused == 2'h0)
    else $error("unused bits stored");
endmodule

//--- bench/bertc_eut.sv
// Purpose: far-side equipment model: bit clocks, serial echo, bit counts
// Assumes: one bit every four core_clk cycles
// Notes:   clock stands still while hold is high, so the transmitter stalls
`timescale 1ns/10ps
module bertc_eut (
  input  wire logic        core_clk,
  input  wire logic        hold,
  input  wire logic        corrupt,
  input  wire logic        tx_data,
  output logic             bit_clk,
  output logic             rx_data,
  output logic [15:0]      nbits,
  output logic [15:0]      ones
);
  logic [1:0] cnt;
  initial begin
    cnt = 2'h0;
    bit_clk = 1'b0;
    rx_data = 1'b0;
    nbits = 16'h0;
    ones = 16'h0;
  end
  // clock high one cycle in four keeps it low between rises
  always @(posedge core_clk) begin
    if (!hold || cnt != 2'h0) begin
      cnt <= cnt + 2'h1;
    end
    bit_clk <= (cnt == 2'h0) && !hold;
    if (cnt == 2'h3) begin
      rx_data <= tx_data ^ corrupt;
      nbits   <= nbits + 16'h1;
      ones    <= ones + {15'h0, tx_data};
    end
  end
endmodule

//--- bench/bertc_top_bench.sv
// Purpose: self-checking bench of the pattern control block
// Assumes: far side echoes the transmit line, counts taken over whole periods
// Notes:   rates rarer than one in a thousand would take too long to run
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module bertc_top_bench import bertc_pkg::*;;
  logic        core_clk, nrst, ale, cs_n, rd_n, wr_n, ad_oe, tx_load_pin;
  logic        count_latch_pin, rx_capture_pin, bit_clk, tx_disable, tx_data;
  logic        rx_data, in_sync, count_clear, realign_pulse, auto_realign_disable;
  logic        rx_bit, rx_bit_valid, hold, corrupt;
  logic [7:0]  ad_in, ad_out;
  logic [31:0] bit_count_in, err_count_in;
  logic [15:0] nbits, ones, rx_ones;
  int          errors, comparisons, n_clear, n_realign;
  bertc_top u_bertc_top (.core_clk, .nrst, .ale, .cs_n, .rd_n, .wr_n, .ad_in, .ad_out,
    .ad_oe, .tx_load_pin, .count_latch_pin, .rx_capture_pin, .tx_clk(bit_clk),
    .tx_disable, .tx_data, .rx_clk(bit_clk), .rx_data, .in_sync, .bit_count_in,
    .err_count_in, .count_clear, .realign_pulse, .auto_realign_disable, .rx_bit,
    .rx_bit_valid);
  bertc_eut u_bertc_eut (.core_clk, .hold, .corrupt, .tx_data, .bit_clk, .rx_data,
    .nbits, .ones);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // counting waits for reset release so an unknown output never poisons a sum
  always @(posedge core_clk) begin
    if (nrst) begin
      n_clear   <= n_clear + int'(count_clear);
      n_realign <= n_realign + int'(realign_pulse);
      rx_ones   <= rx_ones + {15'h0, rx_bit_valid & rx_bit};
    end
  end
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ale <= 1'b1;
    ad_in <= a;
    @(posedge core_clk);
    ale <= 1'b0;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    ad_in <= d;
    @(posedge core_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    ale <= 1'b1;
    ad_in <= a;
    @(posedge core_clk);
    ale <= 1'b0;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(ad_out, e)
    `CHK(ad_oe, 1'b1)
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
  // counts transmitted and received ones over the next n line bits
  task automatic bits(input int n, output int k, output int r);
    logic [15:0] b0;
    logic [15:0] o0;
    logic [15:0] q0;
    int i;
    b0 = nbits;
    o0 = ones;
    q0 = rx_ones;
    for (i = 0; i < 8 * n + 40 && int'(16'(nbits - b0)) < n; i++) begin
      @(posedge core_clk);
    end
    if (int'(16'(nbits - b0)) < n) begin
      errors++;
      stop_test();
    end
    k = int'(16'(ones - o0));
    r = int'(16'(rx_ones - q0));
  endtask
  task automatic t_regs();
    rd_chk(ADDR_TAP, 8'h00);
    rd_chk(ADDR_ERRINS, 8'h00);
    wr(ADDR_TAP, 8'h15);
    rd_chk(ADDR_TAP, 8'h15);
    wr(ADDR_TAP, 8'h00);
    wr(ADDR_BITCNT0, 8'h55);
    rd_chk(ADDR_BITCNT0, 8'h00);
    rd_chk(8'h3c, 8'h00);
    $display("regs done");
  endtask
  task automatic t_zero();
    int k;
    int r;
    int p;
    int e;
    bits(8, k, r);
    bits(40, k, r);
    `CHK(k, 0)
    p = 40;
    for (e = 1; e <= 3; e++) begin
      wr(ADDR_ERRINS, 8'(e));
      bits(4, k, r);
      bits(p, k, r);
      `CHK(k, 4)
      p = p * 10;
    end
    wr(ADDR_ERRINS, 8'h08);
    bits(20, k, r);
    `CHK(k, 1)
    wr(ADDR_ERRINS, 8'h08);
    bits(20, k, r);
    `CHK(k, 0)
    wr(ADDR_ERRINS, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    bits(20, k, r);
    bits(45, k, r);
    `CHK(k, 3)
    wr(ADDR_CTRL, 8'h00);
    $display("zero pattern done");
  endtask
  task automatic t_rx();
    int k;
    int r;
    corrupt <= 1'b1;
    wr(ADDR_ERRINS, 8'h20);
    bits(8, k, r);
    bits(16, k, r);
    `CHK(k, 16)
    `CHK(r, 0)
    wr(ADDR_CTRL, 8'h01);
    hold <= 1'b1;
    repeat (40) @(posedge core_clk);
    hold <= 1'b0;
    bits(8, k, r);
    bits(16, k, r);
    `CHK(r, 16)
    `CHK(k, 16)
    wr(ADDR_ERRINS, 8'h30);
    bits(8, k, r);
    bits(16, k, r);
    `CHK(r, 0)
    wr(ADDR_ERRINS, 8'h20);
    bits(40, k, r);
    rx_capture_pin <= 1'b1;
    bits(4, k, r);
    rx_capture_pin <= 1'b0;
    rd_chk(ADDR_RXPAT3, 8'hff);
    rd_chk(ADDR_RXPAT0, 8'hff);
    // in sync: a capture must leave the old pattern in place
    in_sync <= 1'b1;
    wr(ADDR_ERRINS, 8'h30);
    bits(40, k, r);
    rx_capture_pin <= 1'b1;
    bits(4, k, r);
    rx_capture_pin <= 1'b0;
    rd_chk(ADDR_RXPAT0, 8'hff);
    in_sync <= 1'b0;
    corrupt <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_ERRINS, 8'h00);
    $display("receive path done");
  endtask
  task automatic t_prbs();
    int k;
    int r;
    int a;
    for (a = 0; a < 4; a++) begin
      wr(8'(a), 8'hff);
    end
    wr(ADDR_LENGTH, 8'h02);
    wr(ADDR_CTRL, 8'h20);
    tx_load_pin <= 1'b1;
    bits(4, k, r);
    tx_load_pin <= 1'b0;
    bits(8, k, r);
    bits(14, k, r);
    `CHK(k, 8)
    wr(ADDR_LENGTH, 8'h04);
    wr(ADDR_TAP, 8'h01);
    wr(ADDR_CTRL, 8'ha0);
    bits(8, k, r);
    bits(62, k, r);
    `CHK(k, 32)
    wr(ADDR_CTRL, 8'h20);
    $display("pseudorandom done");
  endtask
  task automatic t_ctl();
    int k;
    int r;
    int c;
    bit_count_in <= 32'h12345678;
    err_count_in <= 32'h9abcdef0;
    c = n_clear;
    wr(ADDR_CTRL, 8'h10);
    bits(4, k, r);
    `CHK(n_clear, c + 1)
    rd_chk(ADDR_BITCNT3, 8'h12);
    rd_chk(ADDR_BITCNT0, 8'h78);
    rd_chk(ADDR_ERRCNT3, 8'h9a);
    rd_chk(ADDR_ERRCNT0, 8'hf0);
    wr(ADDR_CTRL, 8'h00);
    bit_count_in <= 32'h00000011;
    count_latch_pin <= 1'b1;
    bits(4, k, r);
    count_latch_pin <= 1'b0;
    `CHK(n_clear, c + 2)
    rd_chk(ADDR_BITCNT0, 8'h11);
    c = n_realign;
    wr(ADDR_CTRL, 8'h04);
    `CHK(auto_realign_disable, 1'b1)
    wr(ADDR_CTRL, 8'h06);
    bits(4, k, r);
    wr(ADDR_CTRL, 8'h00);
    `CHK(n_realign, c + 1)
    `CHK(auto_realign_disable, 1'b0)
    $display("controls done");
  endtask
  initial begin
    {nrst, ale, tx_load_pin, count_latch_pin, rx_capture_pin} = 5'h00;
    {cs_n, wr_n, rd_n, tx_disable, in_sync, hold, corrupt} = 7'h70;
    ad_in = 8'h00;
    bit_count_in = 32'h0;
    err_count_in = 32'h0;
    {errors, comparisons, n_clear, n_realign} = '0;
    rx_ones = 16'h0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_zero();
    t_rx();
    t_prbs();
    t_ctl();
    stop_test();
  end
endmodule
